// *** core/qtf_formatter.sv ***
// Query terminator formatter: inserts response, channel, scan and block
// terminators and reading separators into the response byte stream.
// Assumes an upstream response source on sys_clk that tags the byte after
// which a boundary falls, and a sink that may stall with out_ready.
`timescale 1ns/100ps
module qtf_formatter
  import qtf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [7:0] src_data,
  input wire logic [2:0] src_class,
  input wire logic [2:0] src_tag,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  typedef struct packed {
    qtf_state_t state;
    logic [QTF_CFG_W-1:0] cfg;
    logic [7:0] uchar;
    logic binmode;
    logic qry_pend;
    logic [QTF_CFG_W-1:0] snap_cfg;
    logic [7:0] snap_uchar;
    logic snap_bin;
    logic [2:0] cls;
    logic in_resp;
    logic [3:0] emit_code;
    logic [1:0] emit_idx;
    logic emit_last;
    logic [4:0] qidx;
    logic out_valid;
    logic [7:0] out_data;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qtf_regs_t;

  localparam qtf_regs_t QTF_REGS_RST = '{
    state: QTF_ST_PASS,
    cfg: QTF_CFG_RST,
    uchar: QTF_UCHAR_RST,
    snap_cfg: QTF_CFG_RST,
    snap_uchar: QTF_UCHAR_RST,
    default: '0
  };

  qtf_regs_t r;
  qtf_regs_t next_r;
  logic [1:0] term_len;
  logic [7:0] term_b0;
  logic [7:0] term_b1;

  // Picks the terminator for a boundary; separator maps to the user code
  function automatic logic [3:0] qtf_pick(input logic [2:0] cls, input logic [2:0] tag,
                                          input logic [QTF_CFG_W-1:0] cfg, input logic bin);
    logic is_buf;
    logic [3:0] code;
    is_buf = (cls == QTF_CLS_BUF1) || (cls == QTF_CLS_BUF2) || (cls == QTF_CLS_BUF3);
    code = QTF_TERM_NONE;
    if (cls == QTF_CLS_GEN)
    begin
      if (tag == QTF_TAG_RESP)
        code = cfg[QTF_RESP_POS +: 4];
    end
    else if (cls == QTF_CLS_HLL)
    begin
      if (tag == QTF_TAG_CHAN)
        code = cfg[QTF_HLL_POS +: 4];
      else if (tag == QTF_TAG_RESP)
        code = cfg[QTF_SCAN_POS +: 4];
    end
    else if (is_buf)
    begin
      if (tag == QTF_TAG_READING && cfg[QTF_SEP_POS])
        code = QTF_TERM_USER;
      else if (tag == QTF_TAG_SCAN)
        code = cfg[QTF_SCAN_POS +: 4];
      else if (tag == QTF_TAG_BLOCK)
        code = cfg[QTF_BLOCK_POS +: 4];
      else if (tag == QTF_TAG_RESP)
        code = (cls == QTF_CLS_BUF1) ? cfg[QTF_SCAN_POS +: 4] : cfg[QTF_BLOCK_POS +: 4];
    end
    if (bin)
      code = QTF_TERM_NONE;
    return code;
  endfunction

  // One byte of the settings query text, index 0 to 18
  function automatic logic [7:0] qtf_qry_byte(input logic [4:0] idx, input logic [QTF_CFG_W-1:0] cfg);
    logic [4:0] j;
    logic [2:0] fld;
    logic [3:0] val;
    logic [3:0] ones;
    j = idx - 5'd1;
    fld = j[4:2];
    val = (fld == 3'd4) ? {3'b000, cfg[QTF_SEP_POS]} : cfg[fld[1:0]*4 +: 4];
    ones = (val >= QTF_TERM_MAX) ? val - QTF_TERM_MAX : val;
    if (idx == 5'd0)
      return QTF_CH_Q;
    case (j[1:0])
      2'd0: return (val >= QTF_TERM_MAX) ? QTF_CH_ZERO + 8'h01 : QTF_CH_ZERO;
      2'd1: return QTF_CH_ZERO + {4'h0, ones};
      2'd2: return QTF_CH_COMMA;
      default: return QTF_CH_SPACE;
    endcase
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] qtf_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res;
  endfunction

  qtf_term_decode u_term (
    .code(r.emit_code),
    .user_char(r.snap_uchar),
    .term_len(term_len),
    .term_b0(term_b0),
    .term_b1(term_b1)
  );

  // Output register frees when empty or when the sink takes the byte
  logic out_free;
  logic src_take;
  logic wr_fire;
  logic qry_set;
  logic [31:0] cur_cfg;
  logic [31:0] cur_ctrl;
  logic [31:0] rd_val;
  logic rd_ok;

  assign out_free = !r.out_valid || out_ready;
  assign src_take = src_valid && src_ready;
  assign src_ready = (r.state == QTF_ST_PASS) && out_free && !(r.qry_pend && !r.in_resp);
  assign wr_fire = r.aw_held && r.w_held && !r.bvalid;
  assign cur_cfg = {15'h0, r.cfg};
  assign cur_ctrl = {30'h0, 1'b0, r.binmode};

  // Register read decode
  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr & 8'hFC)
      QTF_TERM_CFG_OFS: rd_val = cur_cfg;
      QTF_USER_CHAR_OFS: rd_val = {24'h000000, r.uchar};
      QTF_CTRL_OFS: rd_val = cur_ctrl;
      QTF_STATUS_OFS: rd_val = {27'h0, r.out_valid, r.qry_pend, r.state == QTF_ST_QRY,
                                r.state == QTF_ST_EMIT, r.in_resp};
      default: rd_ok = 1'b0;
    endcase
  end

  // Next-state logic for bus slave, settings and byte stream
  always_comb
  begin
    logic [31:0] merged;
    next_r = r;
    merged = 32'h00000000;
    qry_set = 1'b0;
    // Bus: address and data taken in either order, response after both
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_held = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = QTF_RESP_OKAY;
      case (r.aw_addr & 8'hFC)
        QTF_TERM_CFG_OFS:
        begin
          merged = qtf_merge(cur_cfg, r.wdata, r.wstrb);
          next_r.cfg = merged[QTF_CFG_W-1:0];
        end
        QTF_USER_CHAR_OFS:
        begin
          merged = qtf_merge({24'h000000, r.uchar}, r.wdata, r.wstrb);
          next_r.uchar = merged[7:0];
        end
        QTF_CTRL_OFS:
        begin
          merged = qtf_merge(cur_ctrl, r.wdata, r.wstrb);
          next_r.binmode = merged[QTF_CTRL_BIN_POS];
          qry_set = merged[QTF_CTRL_QRY_POS];
        end
        QTF_STATUS_OFS: next_r.bresp = QTF_RESP_OKAY;
        default: next_r.bresp = QTF_RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = rd_ok ? QTF_RESP_OKAY : QTF_RESP_SLVERR;
    end
    else if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    // Output register drains into the sink
    if (r.out_valid && out_ready)
      next_r.out_valid = 1'b0;
    // Byte stream engine
    case (r.state)
      QTF_ST_PASS:
      begin
        if (r.qry_pend && !r.in_resp && out_free)
        begin
          // Settings query waits for a quiet stream, then snapshots like any response
          next_r.qry_pend = 1'b0;
          next_r.in_resp = 1'b1;
          next_r.cls = QTF_CLS_GEN;
          next_r.snap_cfg = r.cfg;
          next_r.snap_uchar = r.uchar;
          next_r.snap_bin = r.binmode;
          next_r.qidx = 5'd0;
          next_r.state = QTF_ST_QRY;
        end
        else if (src_take)
        begin
          next_r.out_valid = 1'b1;
          next_r.out_data = src_data;
          next_r.in_resp = 1'b1;
          if (!r.in_resp)
          begin
            // First byte locks settings for the whole response
            next_r.cls = src_class;
            next_r.snap_cfg = r.cfg;
            next_r.snap_uchar = r.uchar;
            next_r.snap_bin = r.binmode;
          end
          if (src_tag != QTF_TAG_NONE)
          begin
            next_r.emit_code = r.in_resp ? qtf_pick(r.cls, src_tag, r.snap_cfg, r.snap_bin)
                                         : qtf_pick(src_class, src_tag, r.cfg, r.binmode);
            next_r.emit_idx = 2'd0;
            next_r.emit_last = (src_tag == QTF_TAG_RESP);
            next_r.state = QTF_ST_EMIT;
          end
        end
      end
      QTF_ST_QRY:
      begin
        if (out_free)
        begin
          next_r.out_valid = 1'b1;
          next_r.out_data = qtf_qry_byte(r.qidx, r.snap_cfg);
          next_r.qidx = r.qidx + 5'd1;
          if (r.qidx == QTF_QRY_LAST)
          begin
            next_r.emit_code = qtf_pick(QTF_CLS_GEN, QTF_TAG_RESP, r.snap_cfg, r.snap_bin);
            next_r.emit_idx = 2'd0;
            next_r.emit_last = 1'b1;
            next_r.state = QTF_ST_EMIT;
          end
        end
      end
      QTF_ST_EMIT:
      begin
        if (r.emit_idx < term_len)
        begin
          if (out_free)
          begin
            next_r.out_valid = 1'b1;
            next_r.out_data = (r.emit_idx == 2'd0) ? term_b0 : term_b1;
            next_r.emit_idx = r.emit_idx + 2'd1;
          end
        end
        else
        begin
          // A none code costs one idle cycle; a response terminator closes the response here
          next_r.state = QTF_ST_PASS;
          if (r.emit_last)
            next_r.in_resp = 1'b0;
        end
      end
      default: next_r.state = QTF_ST_PASS;
    endcase
    // A query request written in the same cycle as the start wins
    if (qry_set)
      next_r.qry_pend = 1'b1;
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= QTF_REGS_RST;
    else
      r <= next_r;
  end

  // Bus handshakes: one write and one read in flight
  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready = !r.w_held && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign out_valid = r.out_valid;
  assign out_data = r.out_data;

endmodule

// *** core/qtf_pkg.sv ***
// Package for the query terminator formatter: register map, field layout,
// terminator codes, stream tags and state encoding.
// Assumes a 32-bit AXI4-Lite register bus and a byte stream on one clock.
package qtf_pkg;

  // Register byte offsets
  localparam logic [7:0] QTF_TERM_CFG_OFS = 8'h00;
  localparam logic [7:0] QTF_USER_CHAR_OFS = 8'h04;
  localparam logic [7:0] QTF_CTRL_OFS = 8'h08;
  localparam logic [7:0] QTF_STATUS_OFS = 8'h0C;

  // Terminator configuration fields
  localparam int QTF_RESP_POS = 0;
  localparam int QTF_HLL_POS = 4;
  localparam int QTF_SCAN_POS = 8;
  localparam int QTF_BLOCK_POS = 12;
  localparam int QTF_SEP_POS = 16;
  localparam int QTF_CFG_W = 17;
  localparam logic [16:0] QTF_CFG_RST = 17'h00000;
  localparam logic [7:0] QTF_UCHAR_RST = 8'h0A;

  // Control bits
  localparam int QTF_CTRL_BIN_POS = 0;
  localparam int QTF_CTRL_QRY_POS = 1;

  // AXI responses
  localparam logic [1:0] QTF_RESP_OKAY = 2'h0;
  localparam logic [1:0] QTF_RESP_SLVERR = 2'h2;

  // Terminator type codes
  localparam logic [3:0] QTF_TERM_NONE = 4'h0;
  localparam logic [3:0] QTF_TERM_USER = 4'h9;
  localparam logic [3:0] QTF_TERM_MAX = 4'hA;

  // Characters
  localparam logic [7:0] QTF_CR = 8'h0D;
  localparam logic [7:0] QTF_LF = 8'h0A;
  localparam logic [7:0] QTF_CH_Q = 8'h51;
  localparam logic [7:0] QTF_CH_ZERO = 8'h30;
  localparam logic [7:0] QTF_CH_COMMA = 8'h2C;
  localparam logic [7:0] QTF_CH_SPACE = 8'h20;
  localparam logic [4:0] QTF_QRY_LAST = 5'h12;

  // Response classes
  localparam logic [2:0] QTF_CLS_GEN = 3'h0;
  localparam logic [2:0] QTF_CLS_HLL = 3'h1;
  localparam logic [2:0] QTF_CLS_BUF1 = 3'h2;
  localparam logic [2:0] QTF_CLS_BUF2 = 3'h3;
  localparam logic [2:0] QTF_CLS_BUF3 = 3'h4;

  // Boundary tags on a source byte
  localparam logic [2:0] QTF_TAG_NONE = 3'h0;
  localparam logic [2:0] QTF_TAG_READING = 3'h1;
  localparam logic [2:0] QTF_TAG_CHAN = 3'h2;
  localparam logic [2:0] QTF_TAG_SCAN = 3'h3;
  localparam logic [2:0] QTF_TAG_BLOCK = 3'h4;
  localparam logic [2:0] QTF_TAG_RESP = 3'h5;

  typedef enum logic [2:0] {
    QTF_ST_PASS = 3'b001,
    QTF_ST_EMIT = 3'b010,
    QTF_ST_QRY = 3'b100
  } qtf_state_t;

endpackage

// *** core/qtf_term_decode.sv ***
// Terminator type decoder: turns a terminator code into up to two bytes.
// Purely combinational; the caller holds code and user character stable.
`timescale 1ns/100ps
module qtf_term_decode
  import qtf_pkg::*;
(
  input wire logic [3:0] code,
  input wire logic [7:0] user_char,
  output logic [1:0] term_len,
  output logic [7:0] term_b0,
  output logic [7:0] term_b1
);

  // Pairs of codes share one meaning; codes above ten emit nothing
  always_comb
  begin
    term_len = 2'd0;
    term_b0 = QTF_CR;
    term_b1 = QTF_LF;
    case (code)
      4'h1, 4'h2:
      begin
        term_len = 2'd2;
      end
      4'h3, 4'h4:
      begin
        term_len = 2'd2;
        term_b0 = QTF_LF;
        term_b1 = QTF_CR;
      end
      4'h5, 4'h6:
      begin
        term_len = 2'd1;
      end
      4'h7, 4'h8:
      begin
        term_len = 2'd1;
        term_b0 = QTF_LF;
      end
      4'h9, 4'hA:
      begin
        term_len = 2'd1;
        term_b0 = user_char;
      end
      default:
      begin
        term_len = 2'd0;
      end
    endcase
  end

endmodule

// *** sim/qtf_formatter_asserts.sv ***
// Checker on the formatter top ports: bus answers and byte stream.
// Bound onto qtf_formatter; one clock, reset_n asynchronous active low.
`timescale 1ns/100ps
module qtf_formatter_asserts
  import qtf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic [7:0] src_data,
  input wire logic [2:0] src_class,
  input wire logic [2:0] src_tag,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data
);
  // One domain, so clock and reset stand once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Stream: a stalled byte stands and blocks the source
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("held byte changed");
  src_block_a: assert property (out_valid && !out_ready |-> !src_ready)
    else $error("source taken while stalled");
  byte_pass_a: assert property (src_valid && src_ready |=> out_valid && out_data == $past(src_data))
    else $error("source byte not forwarded");
  // Bus: one write and one read at a time, reads answered one edge later, writes two edges later
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  // Both channels taken on one edge: both are held one edge later, register and answer update together the edge after
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
    |=> s_axi_rresp == QTF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  // Main scenarios reached
  cover property (src_valid && src_ready && src_tag == QTF_TAG_BLOCK);
  cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  cover property (s_axi_bvalid && s_axi_bresp == QTF_RESP_SLVERR);
endmodule

bind qtf_formatter qtf_formatter_asserts i_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .src_class(src_class),
  .src_tag(src_tag), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);

// *** sim/qtf_sink_model.sv ***
// Host-side byte sink: records every output byte it accepts.
// One clock; stalls at random so held bytes get exercised.
`timescale 1ns/100ps
module qtf_sink_model
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] got_q[$];

  // Take a byte at each handshake edge, then redraw the stall
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      out_ready <= 1'b0;
    else
    begin
      if (out_valid && out_ready)
        got_q.push_back(out_data);
      out_ready <= ($urandom % 4) != 0;
    end
  end
endmodule

// *** sim/test_qtf_formatter.sv ***
// Self-checking bench for the formatter: bus tasks, byte source, expected streams.
// The sink model drains and records the output with random stalls.
`timescale 1ns/100ps
module test_qtf_formatter;
  import qtf_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, sv = 1'b0;
  logic [7:0] adr = 8'h00, sd = 8'h00, od, uch;
  logic [31:0] wd = 32'h0, rdt, rd;
  logic [2:0] sc = 3'h0, st = 3'h0;
  logic [1:0] br, rr, resp;
  logic awr, wrd, bv, arr, rv, sr, ov, ordy;
  logic [7:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  qtf_formatter i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(adr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(adr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .src_valid(sv),
    .src_ready(sr), .src_data(sd), .src_class(sc), .src_tag(st), .out_valid(ov), .out_ready(ordy),
    .out_data(od)
  );
  qtf_sink_model i_sink (
    .sys_clk(sys_clk), .reset_n(reset_n), .out_valid(ov), .out_data(od), .out_ready(ordy)
  );

  // Verdict and end of run
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Case equality, so an unknown never passes
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    samples_checked++;
    if (got !== want)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // A wait that ran out ends the run
  task automatic waited(input int n);
    if (n >= 200)
    begin
      errors++;
      $display("wrong value at %0t: wait ran out", $time);
      summarize();
    end
  endtask

  // One bus transfer; each channel is dropped at the edge that takes it
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_go, w_go, ar_go, done;
    @(posedge sys_clk);
    adr <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bre <= w;
    arv <= !w;
    rre <= !w;
    done = 1'b0;
    n = 0;
    while (!done && n < 200)
    begin
      @(negedge sys_clk);
      aw_go = awv && awr;
      w_go = wv && wrd;
      ar_go = arv && arr;
      done = w ? bv : rv;
      resp = w ? br : rr;
      rd = rdt;
      @(posedge sys_clk);
      if (aw_go)
        awv <= 1'b0;
      if (w_go)
        wv <= 1'b0;
      if (ar_go)
        arv <= 1'b0;
      n++;
    end
    bre <= 1'b0;
    rre <= 1'b0;
    waited(n);
  endtask

  // Offer one source byte until it is taken
  task automatic send(input logic [7:0] d, input logic [2:0] c, input logic [2:0] t);
    int n;
    logic go;
    @(posedge sys_clk);
    sd <= d;
    sc <= c;
    st <= t;
    sv <= 1'b1;
    go = 1'b0;
    n = 0;
    while (!go && n < 200)
    begin
      @(negedge sys_clk);
      go = sr;
      @(posedge sys_clk);
      n++;
    end
    sv <= 1'b0;
    waited(n);
  endtask

  // Sampled at the falling edge, clear of the sink's own updates
  task automatic expect_stream();
    int n;
    n = 0;
    while (i_sink.got_q.size() < exp_q.size() && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    waited(n);
    check(32'(i_sink.got_q.size()), 32'(exp_q.size()), "length");
    foreach (exp_q[i])
      check({24'h0, i_sink.got_q[i]}, {24'h0, exp_q[i]}, "byte");
    i_sink.got_q.delete();
  endtask

  // Expected terminator bytes for one code
  function automatic void add_term(input logic [3:0] c);
    case (c)
      4'h1, 4'h2: exp_q = {exp_q, QTF_CR, QTF_LF};
      4'h3, 4'h4: exp_q = {exp_q, QTF_LF, QTF_CR};
      4'h5, 4'h6: exp_q.push_back(QTF_CR);
      4'h7, 4'h8: exp_q.push_back(QTF_LF);
      4'h9, 4'hA: exp_q.push_back(uch);
      default: ;
    endcase
  endfunction

  // Two decimal digits of a setting
  function automatic void add_num(input logic [3:0] v);
    exp_q.push_back(QTF_CH_ZERO + 8'(v / 10));
    exp_q.push_back(QTF_CH_ZERO + 8'(v % 10));
  endfunction

  function automatic logic [31:0] cfg_word(input logic [3:0] r, input logic [3:0] h, input logic [3:0] s,
    input logic [3:0] b, input logic p);
    return {15'h0, p, b, s, h, r};
  endfunction

  // Main sequence
  initial
  begin
    logic [3:0] f [5];
    logic [2:0] cls;
    void'($urandom(75));
    repeat (16)
      @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values, then unmapped places
    axi(1'b0, QTF_TERM_CFG_OFS, 32'h0);
    check(rd, {15'h0, QTF_CFG_RST}, "cfg reset");
    axi(1'b0, QTF_USER_CHAR_OFS, 32'h0);
    check(rd, {24'h0, QTF_UCHAR_RST}, "uchar reset");
    axi(1'b0, 8'h40, 32'h0);
    check({30'h0, resp}, {30'h0, QTF_RESP_SLVERR}, "unmapped read");
    axi(1'b1, 8'h44, 32'h1);
    check({30'h0, resp}, {30'h0, QTF_RESP_SLVERR}, "unmapped write");
    uch = 8'($urandom_range(126, 33));
    axi(1'b1, QTF_USER_CHAR_OFS, {24'h0, uch});
    check({30'h0, resp}, {30'h0, QTF_RESP_OKAY}, "mapped write");
    // Codes 0 to 10 on a general response
    for (int k = 0; k < 11; k++)
    begin
      axi(1'b1, QTF_TERM_CFG_OFS, cfg_word(4'(k), 4'h0, 4'h0, 4'h0, 1'b0));
      exp_q = {8'h41, 8'h42};
      add_term(4'(k));
      send(8'h41, QTF_CLS_GEN, QTF_TAG_NONE);
      send(8'h42, QTF_CLS_GEN, QTF_TAG_RESP);
      expect_stream();
    end
    // Random settings over last-reading, buffer and settings-query output
    repeat (3)
    begin
      foreach (f[i])
        f[i] = 4'($urandom_range(10, 1));
      axi(1'b1, QTF_TERM_CFG_OFS, cfg_word(f[0], f[1], f[2], f[3], f[4][0]));
      exp_q = {8'h31};
      add_term(f[1]);
      exp_q.push_back(8'h32);
      add_term(f[2]);
      send(8'h31, QTF_CLS_HLL, QTF_TAG_CHAN);
      send(8'h32, QTF_CLS_HLL, QTF_TAG_RESP);
      expect_stream();
      for (int m = 0; m < 3; m++)
      begin
        cls = QTF_CLS_BUF1 + 3'(m);
        exp_q = {8'h61};
        if (f[4][0])
          exp_q.push_back(uch);
        send(8'h61, cls, QTF_TAG_READING);
        if (m > 0)
        begin
          send(8'h62, cls, QTF_TAG_SCAN);
          send(8'h63, cls, QTF_TAG_BLOCK);
          exp_q.push_back(8'h62);
          add_term(f[2]);
          exp_q.push_back(8'h63);
          add_term(f[3]);
        end
        send(8'h64, cls, QTF_TAG_RESP);
        exp_q.push_back(8'h64);
        add_term(m > 0 ? f[3] : f[2]);
        expect_stream();
      end
      exp_q = {QTF_CH_Q};
      for (int i = 0; i < 5; i++)
      begin
        if (i > 0)
          exp_q = {exp_q, QTF_CH_COMMA, QTF_CH_SPACE};
        add_num(i < 4 ? f[i] : {3'h0, f[4][0]});
      end
      add_term(f[0]);
      axi(1'b1, QTF_CTRL_OFS, 32'h2);
      expect_stream();
    end
    // Binary mode drops separators and terminators
    axi(1'b1, QTF_TERM_CFG_OFS, cfg_word(4'h5, 4'h5, 4'h5, 4'h5, 1'b1));
    axi(1'b1, QTF_CTRL_OFS, 32'h1);
    exp_q = {8'h45, 8'h46};
    send(8'h45, QTF_CLS_BUF2, QTF_TAG_READING);
    send(8'h46, QTF_CLS_BUF2, QTF_TAG_RESP);
    expect_stream();
    // A change in mid-response waits for the next response
    axi(1'b1, QTF_CTRL_OFS, 32'h0);
    send(8'h58, QTF_CLS_GEN, QTF_TAG_NONE);
    axi(1'b1, QTF_TERM_CFG_OFS, cfg_word(4'h7, 4'h0, 4'h0, 4'h0, 1'b0));
    send(8'h59, QTF_CLS_GEN, QTF_TAG_RESP);
    exp_q = {8'h58, 8'h59, QTF_CR};
    expect_stream();
    summarize();
  end
endmodule
